//--- design/tma_pkg.sv
// shared constants, types and reset image for the temperature alarm block
package tma_pkg;

  // ==========================================================
  // register pointer map
  localparam logic [7:0] TMA_A_TEMP_BASE = 8'h00; // remote n at base+n
  localparam logic [7:0] TMA_A_ALIM_BASE = 8'h10; // remote n at base+n
  localparam logic [2:0] TMA_LOCAL_OFS   = 3'h7;  // local sits at base+7
  localparam logic [7:0] TMA_A_EXT1      = 8'h09;
  localparam logic [7:0] TMA_A_MFR       = 8'h0A;
  localparam logic [7:0] TMA_A_CFG1      = 8'h41;
  localparam logic [7:0] TMA_A_CFG2      = 8'h42;
  localparam logic [7:0] TMA_A_CFG3      = 8'h43;
  localparam logic [7:0] TMA_A_STAT1     = 8'h44;
  localparam logic [7:0] TMA_A_STAT2     = 8'h45;
  localparam logic [7:0] TMA_A_STAT3     = 8'h46;
  localparam logic [3:0][7:0] TMA_A_OLIM =
    {8'h26, 8'h25, 8'h24, 8'h21};

  // ==========================================================
  // configuration fields
  localparam int TMA_C1_STOP = 7;
  localparam int TMA_C1_POR  = 6;
  localparam int TMA_C1_TMO  = 5;
  localparam int TMA_C1_FAST = 4;
  localparam int TMA_C1_RCAN = 3;
  localparam logic [7:0] TMA_C1_WMASK = 8'hB8; // reset bit is not stored
  localparam logic [7:0] TMA_C2_WMASK = 8'h7F;
  localparam logic [7:0] TMA_C3_WMASK = 8'h39;
  localparam int TMA_ST_LOCAL = 6;             // local channel status bit

  // ==========================================================
  // channels, data format, timing
  localparam int TMA_NCHAN = 7;                // 0 local, 1..6 remote
  localparam int TMA_NOVT  = 4;
  localparam logic [2:0] TMA_CH_FAST = 3'h1;
  localparam logic [2:0] TMA_CH_LAST = 3'h6;
  localparam logic [2:0] TMA_CH_FIRST = 3'h0;
  localparam logic [2:0] TMA_CH_RESUME = 3'h2;
  localparam logic [7:0] TMA_TEMP_MAX  = 8'h7F;
  localparam logic [7:0] TMA_FAULT_VAL = 8'hFF;
  localparam logic [8:0] TMA_OVT_HYST  = 9'h004; // degrees
  localparam int TMA_FRAC_W = 3;
  localparam int TMA_TMO_MS = 37;              // bus timeout, ms
  localparam int TMA_CLK_KHZ = 25000;          // core clock, kHz
  localparam logic [7:0][7:0] TMA_ZERO_B = '0;

  localparam logic [6:0][7:0] TMA_ALIM_RST =
    {8'h64, 8'h64, 8'h64, 8'h64, 8'h64, 8'h7F, 8'h5A};
  localparam logic [3:0][7:0] TMA_OLIM_RST =
    {8'h5A, 8'h5A, 8'h7F, 8'h6E};

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    TMA_K_PTR = 3'h0, TMA_K_WR = 3'h1, TMA_K_RD = 3'h2,
    TMA_K_ARA = 3'h3, TMA_K_ARA_WON = 3'h4
  } tma_kind_e;

  typedef enum logic [1:0] {
    TMA_S_IDLE = 2'b00, TMA_S_START = 2'b01, TMA_S_WAIT = 2'b11
  } tma_seq_e;

  typedef struct packed {
    tma_kind_e  kind;
    logic [7:0] data;
  } tma_req_s;

  typedef struct packed {
    logic       ack;
    logic [7:0] data;
  } tma_rsp_s;

  typedef struct packed {
    logic               done;
    logic               fault;
    logic signed [11:0] temp;  // eighths of a degree
  } tma_conv_s;

endpackage

//--- design/tma_sync2.sv
// two-flop level synchroniser with synchronous clear
`timescale 1ns/1ps
module tma_sync2 (
  input  wire logic clk,
  input  wire logic en,
  input  wire logic clrN,
  input  wire logic d,
  output logic      q
);
  typedef struct packed {
    logic meta;
    logic stable;
  } tma_sync_s;

  tma_sync_s st;
  tma_sync_s nxt_st;

  // meta stage is read only by the stable stage
  always_comb begin
    nxt_st = st;
    if (!clrN) begin
      nxt_st = '0;
    end else if (en) begin
      nxt_st.meta   = d;
      nxt_st.stable = st.meta;
    end
  end

  always_ff @(posedge clk) begin
    st <= nxt_st;
  end

  assign q = st.stable;
endmodule // tma_sync2

//--- design/tma_link_xfer.sv
// toggle handshake carrying bus requests and answers between clocks
`timescale 1ns/1ps
module tma_link_xfer import tma_pkg::*; (
  input  wire logic     clk,
  input  wire logic     reset_n,
  input  wire logic     ce,
  input  wire logic     linkClk,
  input  wire logic     linkReqValid,
  input  wire tma_req_s linkReq,
  output logic          linkReqReady,
  output logic          linkRspValid,
  output tma_rsp_s      linkRsp,
  output logic          coreStb,
  output tma_req_s      coreReq,
  input  wire tma_rsp_s coreRsp,
  input  wire logic     coreRspStb
);
  typedef struct packed {
    logic     reqTgl;
    logic     ackSeen;
    logic     ready;
    logic     rspValid;
    tma_req_s req;
    tma_rsp_s rsp;
  } tma_lside_s;

  typedef struct packed {
    logic     reqSeen;
    logic     ackTgl;
    tma_rsp_s rsp;
  } tma_cside_s;

  tma_lside_s lst;
  tma_lside_s nxt_lst;
  tma_cside_s cst;
  tma_cside_s nxt_cst;
  logic       linkRstN;
  logic       reqTglCore;
  logic       ackTglLink;

  // ==========================================================
  // crossings
  tma_sync2 uRstSync (.clk(linkClk), .en(1'b1), .clrN(1'b1),
                      .d(reset_n), .q(linkRstN));
  tma_sync2 uReqSync (.clk(clk), .en(ce), .clrN(reset_n),
                      .d(lst.reqTgl), .q(reqTglCore));
  tma_sync2 uAckSync (.clk(linkClk), .en(1'b1), .clrN(linkRstN),
                      .d(cst.ackTgl), .q(ackTglLink));

  // ==========================================================
  // link side: one request in flight, data held until answered
  always_comb begin
    nxt_lst = lst;
    nxt_lst.rspValid = 1'b0;
    if (!linkRstN) begin
      nxt_lst = '0;
      nxt_lst.ready = 1'b1;
    end else begin
      if (lst.ready && linkReqValid) begin
        nxt_lst.req    = linkReq;
        nxt_lst.reqTgl = ~lst.reqTgl;
        nxt_lst.ready  = 1'b0;
      end
      if (ackTglLink != lst.ackSeen) begin
        nxt_lst.ackSeen  = ackTglLink;
        nxt_lst.rsp      = cst.rsp;   // stable since ackTgl moved
        nxt_lst.rspValid = 1'b1;
        nxt_lst.ready    = 1'b1;
      end
    end
  end

  always_ff @(posedge linkClk) begin
    lst <= nxt_lst;
  end

  // ==========================================================
  // core side: every request is acknowledged, writes answer at once
  always_comb begin
    nxt_cst = cst;
    if (!reset_n) begin
      nxt_cst = '0;
    end else if (ce) begin
      if (reqTglCore != cst.reqSeen) begin
        nxt_cst.reqSeen = reqTglCore;
      end
      if (coreRspStb) begin
        nxt_cst.rsp    = coreRsp;
        nxt_cst.ackTgl = ~cst.ackTgl;
      end
    end
  end

  always_ff @(posedge clk) begin
    cst <= nxt_cst;
  end

  assign coreStb      = ce && reset_n && (reqTglCore != cst.reqSeen);
  assign coreReq      = lst.req;
  assign linkReqReady = lst.ready;
  assign linkRspValid = lst.rspValid;
  assign linkRsp      = lst.rsp;
endmodule // tma_link_xfer

//--- design/tma_alarm_core.sv
// alarm, fault, status and configuration logic of the temperature monitor
`timescale 1ns/1ps

// Summary of operation
// - channel 1 fraction byte holds eighths of a degree in bits 7:5
// - open or shorted remote diode is flagged and never drives alarms
// - diode fault sets channel fault bit and stores all ones
// - fault found by converter, sequencer moves to the next channel
// - seven alert high limits and four overtemperature limits
// - alert event when a channel result exceeds its high limit
// - alert output releases once result falls below the limit
// - status read or alert response clears alert; next conversion resets
// - conversions keep running while the alert is active
// - on alert response a pending device returns its own address
// - losing responder does not clear its alert
// - overtemperature above limit, released below limit minus 4
// - 8-bit pointer selects register, resets to zero
// - config 1 bit 7 stops conversions for standby
// - config 1 bit 6 restores power-on state and clears itself
// - config 1 bit 5 set disables bus timeout
// - config 1 bit 4 fast channel 1, bit 3 resistance cancel
// - config 2 bits 6:0 mask alert, local at bit 6, reset zero
// - config 3 bits 5,4,3,0 mask overtemperature, reset zero
// - three status registers: limit, overtemperature, diode fault
// - alert status clears on read and sets again next conversion
// - alert output follows flags, cleared by status read or response
// - channel 1 has eleven bits, others eight bits of one degree
// - fraction read freezes channel 1 high byte until read or timeout
// - high byte saturates at 7F, reads 00 below zero, FF on fault
module tma_alarm_core import tma_pkg::*; #(
  parameter logic [6:0]  SLAVE_ADDR  = 7'h18,
  parameter logic [7:0]  MFR_ID      = 8'h5C, // arbitrary value
  parameter int unsigned FRZ_TIMEOUT = TMA_TMO_MS * TMA_CLK_KHZ
) (
  input  wire logic      clk,
  input  wire logic      reset_n,
  input  wire logic      ce,
  input  wire logic      linkClk,
  input  wire logic      linkReqValid,
  input  wire tma_req_s  linkReq,
  output logic           linkReqReady,
  output logic           linkRspValid,
  output tma_rsp_s       linkRsp,
  input  wire tma_conv_s conv,
  output logic           convStart,
  output logic [2:0]     convChan,
  output logic           convResCancel,
  output logic           convFastCh1,
  output logic           busTimeoutEn,
  output logic           alertOut_n,
  output logic           overtemp_out_n
);

  typedef struct packed {
    logic [7:0]      ptr;
    logic [7:0]      cfg1;
    logic [7:0]      cfg2;
    logic [7:0]      cfg3;
    logic [6:0][7:0] temp;
    logic [7:0]      ext1;
    logic [6:0][7:0] alim;
    logic [3:0][7:0] olim;
    logic [7:0]      limit_exceed_flags;
    logic [7:0]      overtemp_exceed_flags;
    logic [7:0]      diode_fault_flags;
    logic            alertLatch;
    logic            freeze;
    logic [19:0]     frzCnt;
    tma_seq_e        seq;
    logic [2:0]      chan;
    logic [2:0]      resume;
    logic            convStart;
    tma_rsp_s        rsp;
    logic            rspStb;
    logic            alertOut_n;
    logic            overtOut_n;
  } tma_core_s;

  localparam tma_core_s TMA_CORE_RST = '{
    ptr: 8'h00, cfg1: 8'h00, cfg2: 8'h00, cfg3: 8'h00,
    temp: '0, ext1: 8'h00, alim: TMA_ALIM_RST, olim: TMA_OLIM_RST,
    limit_exceed_flags: 8'h00, overtemp_exceed_flags: 8'h00,
    diode_fault_flags: 8'h00, alertLatch: 1'b0, freeze: 1'b0,
    frzCnt: '0, seq: TMA_S_IDLE, chan: TMA_CH_FIRST,
    resume: TMA_CH_RESUME, convStart: 1'b0, rsp: '0, rspStb: 1'b0,
    alertOut_n: 1'b1, overtOut_n: 1'b1};

  localparam logic [19:0] FRZ_LAST = 20'(FRZ_TIMEOUT - 1);

  tma_core_s st;
  tma_core_s nxt_st;
  logic      coreStb;
  tma_req_s  coreReq;

  // ==========================================================
  // helpers
  // status bit of a channel: local at bit 6, remote n at bit n-1
  function automatic logic [2:0] statBit(input logic [2:0] ch);
    statBit = (ch == TMA_CH_FIRST) ? 3'(TMA_ST_LOCAL) : 3'(ch - 3'h1);
  endfunction

  // overtemperature slot of a channel, valid bit in msb
  function automatic logic [2:0] ovtSlot(input logic [2:0] ch);
    case (ch)
      3'h1:    ovtSlot = 3'h4;
      3'h4:    ovtSlot = 3'h5;
      3'h5:    ovtSlot = 3'h6;
      3'h6:    ovtSlot = 3'h7;
      default: ovtSlot = 3'h0;
    endcase
  endfunction

  // pointer value for a per-channel register
  function automatic logic [7:0] chAddr(input logic [7:0] base,
                                        input logic [2:0] ch);
    chAddr = base + 8'((ch == TMA_CH_FIRST) ? TMA_LOCAL_OFS : ch);
  endfunction

  // register read mux
  function automatic logic [7:0] readReg(input tma_core_s s);
    logic [7:0] v;
    v = 8'h00;                                    // unmapped reads zero
    if (s.ptr == TMA_A_CFG1) begin
      v = s.cfg1;
    end else if (s.ptr == TMA_A_CFG2) begin
      v = s.cfg2;
    end else if (s.ptr == TMA_A_CFG3) begin
      v = s.cfg3;
    end else if (s.ptr == TMA_A_STAT1) begin
      v = s.limit_exceed_flags;
    end else if (s.ptr == TMA_A_STAT2) begin
      v = s.overtemp_exceed_flags;
    end else if (s.ptr == TMA_A_STAT3) begin
      v = s.diode_fault_flags;
    end else if (s.ptr == TMA_A_EXT1) begin
      v = s.ext1;
    end else if (s.ptr == TMA_A_MFR) begin
      v = MFR_ID;
    end else begin
      for (int c = 0; c < TMA_NCHAN; c++) begin
        if (s.ptr == chAddr(TMA_A_TEMP_BASE, 3'(c))) v = s.temp[c];
        if (s.ptr == chAddr(TMA_A_ALIM_BASE, 3'(c))) v = s.alim[c];
      end
      for (int o = 0; o < TMA_NOVT; o++) begin
        if (s.ptr == TMA_A_OLIM[o]) v = s.olim[o];
      end
    end
    return v;
  endfunction

  // ==========================================================
  // request crossing from the bus clock
  tma_link_xfer uXfer (
    .clk          (clk),
    .reset_n      (reset_n),
    .ce           (ce),
    .linkClk      (linkClk),
    .linkReqValid (linkReqValid),
    .linkReq      (linkReq),
    .linkReqReady (linkReqReady),
    .linkRspValid (linkRspValid),
    .linkRsp      (linkRsp),
    .coreStb      (coreStb),
    .coreReq      (coreReq),
    .coreRsp      (st.rsp),
    .coreRspStb   (st.rspStb)
  );

  // ==========================================================
  // next state: bus access, sequencer, conversion results, alarms
  always_comb begin
    logic       rdClr1;
    logic       araClr;
    logic       setEvt;
    logic       softRst;
    logic       exceed;
    logic [7:0] res;
    logic [2:0] frac;
    logic [2:0] sb;
    logic [2:0] os;
    logic [8:0] okLevel;
    rdClr1  = 1'b0;
    araClr  = 1'b0;
    setEvt  = 1'b0;
    softRst = 1'b0;
    exceed  = 1'b0;
    res     = 8'h00;
    frac    = 3'h0;
    sb      = statBit(st.chan);
    os      = ovtSlot(st.chan);
    okLevel = 9'h000;
    nxt_st  = st;
    nxt_st.convStart = 1'b0;
    nxt_st.rspStb    = 1'b0;

    // freeze timeout runs first, so a fraction read in its last
    // cycle still restarts the freeze and the count
    if (st.freeze && !st.cfg1[TMA_C1_TMO]) begin
      nxt_st.frzCnt = st.frzCnt + 20'h00001;
      if (st.frzCnt == FRZ_LAST) begin
        nxt_st.freeze = 1'b0;
      end
    end

    // bus requests, pointer selects the target
    if (coreStb) begin
      case (coreReq.kind)
        TMA_K_PTR: begin
          // pointer set is answered too, or the link never frees
          nxt_st.ptr    = coreReq.data;
          nxt_st.rspStb = 1'b1;
          nxt_st.rsp    = '{ack: 1'b1, data: 8'h00};
        end
        TMA_K_WR: begin
          nxt_st.rspStb   = 1'b1;
          nxt_st.rsp      = '{ack: 1'b1, data: 8'h00};
          if (st.ptr == TMA_A_CFG1) begin
            softRst     = coreReq.data[TMA_C1_POR];
            nxt_st.cfg1 = coreReq.data & TMA_C1_WMASK;
          end else if (st.ptr == TMA_A_CFG2) begin
            nxt_st.cfg2 = coreReq.data & TMA_C2_WMASK;
          end else if (st.ptr == TMA_A_CFG3) begin
            nxt_st.cfg3 = coreReq.data & TMA_C3_WMASK;
          end else begin
            for (int c = 0; c < TMA_NCHAN; c++) begin
              if (st.ptr == chAddr(TMA_A_ALIM_BASE, 3'(c))) begin
                nxt_st.alim[c] = coreReq.data;
              end
            end
            for (int o = 0; o < TMA_NOVT; o++) begin
              if (st.ptr == TMA_A_OLIM[o]) begin
                nxt_st.olim[o] = coreReq.data;
              end
            end
          end
        end
        TMA_K_RD: begin
          nxt_st.rspStb = 1'b1;
          nxt_st.rsp    = '{ack: 1'b1, data: readReg(st)};
          if (st.ptr == TMA_A_STAT1) begin
            rdClr1 = 1'b1;
          end
          if (st.ptr == TMA_A_EXT1) begin
            nxt_st.freeze = 1'b1;
            nxt_st.frzCnt = '0;
          end
          if (st.ptr == chAddr(TMA_A_TEMP_BASE, TMA_CH_FAST)) begin
            nxt_st.freeze = 1'b0;
          end
        end
        TMA_K_ARA: begin
          // only a pending device claims the response
          nxt_st.rspStb = 1'b1;
          nxt_st.rsp    = '{ack: st.alertLatch,
                            data: {SLAVE_ADDR, 1'b0}};
        end
        TMA_K_ARA_WON: begin
          nxt_st.rspStb = 1'b1;
          nxt_st.rsp    = '{ack: st.alertLatch, data: 8'h00};
          araClr        = 1'b1;     // losers never send this
        end
        default: ;
      endcase
    end

    // read clears come before conversion sets, so a set wins
    if (rdClr1) begin
      nxt_st.limit_exceed_flags = 8'h00;
    end

    // round-robin sequencer, alarms never pause it
    case (st.seq)
      TMA_S_IDLE: begin
        if (!st.cfg1[TMA_C1_STOP]) begin
          nxt_st.seq = TMA_S_START;
        end
      end
      TMA_S_START: begin
        nxt_st.convStart = 1'b1;
        nxt_st.seq       = TMA_S_WAIT;
      end
      TMA_S_WAIT: begin
        if (conv.done) begin
          // fault abandons the channel like any other finish
          nxt_st.seq = st.cfg1[TMA_C1_STOP] ? TMA_S_IDLE : TMA_S_START;
          if (st.cfg1[TMA_C1_FAST] && st.chan != TMA_CH_FAST) begin
            nxt_st.chan   = TMA_CH_FAST;
            nxt_st.resume = (st.chan == TMA_CH_LAST) ? TMA_CH_FIRST
                                                     : 3'(st.chan + 3'h1);
          end else if (st.cfg1[TMA_C1_FAST]) begin
            nxt_st.chan = st.resume;
          end else begin
            nxt_st.chan = (st.chan == TMA_CH_LAST) ? TMA_CH_FIRST
                                                   : 3'(st.chan + 3'h1);
          end

          // result format: clamp to 0..127, eighths in the fraction
          if (conv.temp < 0) begin
            res = 8'h00;
          end else if (conv.temp[11:TMA_FRAC_W] > 9'(TMA_TEMP_MAX)) begin
            res = TMA_TEMP_MAX;
          end else begin
            res  = conv.temp[10:TMA_FRAC_W];
            frac = conv.temp[TMA_FRAC_W-1:0];
          end

          if (conv.fault && st.chan != TMA_CH_FIRST) begin
            // faulty channel stores all ones, no alarm
            nxt_st.diode_fault_flags[sb] = 1'b1;
            if (!(st.chan == TMA_CH_FAST && st.freeze)) begin
              nxt_st.temp[st.chan] = TMA_FAULT_VAL;
            end
            nxt_st.limit_exceed_flags[sb] = 1'b0;
            if (os[2]) begin
              nxt_st.overtemp_exceed_flags[sb] = 1'b0;
            end
          end else begin
            if (st.chan != TMA_CH_FIRST) begin
              nxt_st.diode_fault_flags[sb] = 1'b0;
            end
            // high byte and fraction held while a split read is open
            if (!(st.chan == TMA_CH_FAST && st.freeze)) begin
              nxt_st.temp[st.chan] = res;
              if (st.chan == TMA_CH_FAST) begin
                nxt_st.ext1 = {frac, 5'h00};
              end
            end
            exceed = res > st.alim[st.chan];
            if (exceed) begin
              nxt_st.limit_exceed_flags[sb] = 1'b1;
              setEvt = !st.cfg2[sb];
            end else if (res < st.alim[st.chan]) begin
              nxt_st.limit_exceed_flags[sb] = 1'b0;
            end
            if (os[2]) begin
              okLevel = {1'b0, res} + TMA_OVT_HYST;
              if (res > st.olim[os[1:0]]) begin
                nxt_st.overtemp_exceed_flags[sb] = 1'b1;
              end else if (okLevel < {1'b0, st.olim[os[1:0]]}) begin
                nxt_st.overtemp_exceed_flags[sb] = 1'b0;
              end
            end
          end
        end
      end
      default: nxt_st.seq = TMA_S_IDLE;
    endcase

    // alert latch: cleared by read or won response, re-armed by events
    if (rdClr1 || araClr) begin
      nxt_st.alertLatch = 1'b0;
    end
    if (!(|(nxt_st.limit_exceed_flags[6:0] & ~st.cfg2[6:0]))) begin
      nxt_st.alertLatch = 1'b0;
    end
    if (setEvt) begin
      nxt_st.alertLatch = 1'b1;
    end

    // pins from flops; config 3 mask gates only its pin, config 2 mask also gates the alert latch
    nxt_st.alertOut_n = ~nxt_st.alertLatch;
    nxt_st.overtOut_n = ~(|(nxt_st.overtemp_exceed_flags
                            & TMA_C3_WMASK & ~st.cfg3));

    // soft reset restores everything, bit never reads back set
    if (softRst) begin
      nxt_st = TMA_CORE_RST;
      // the write itself is still answered so the link frees
      nxt_st.rspStb = 1'b1;
      nxt_st.rsp    = '{ack: 1'b1, data: 8'h00};
    end
  end

  // ==========================================================
  // state register, frozen while the clock enable is low
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st <= TMA_CORE_RST;
    end else if (ce) begin
      st <= nxt_st;
    end
  end

  assign convStart      = st.convStart;
  assign convChan       = st.chan;
  assign convResCancel  = st.cfg1[TMA_C1_RCAN];
  assign convFastCh1    = st.cfg1[TMA_C1_FAST];
  assign busTimeoutEn   = ~st.cfg1[TMA_C1_TMO];
  assign alertOut_n     = st.alertOut_n;
  assign overtemp_out_n = st.overtOut_n;
endmodule // tma_alarm_core

//--- sim/tma_conv_model.sv
// converter stand-in that answers each conversion start
`timescale 1ns/1ps
module tma_conv_model import tma_pkg::*; (
  input  wire logic       clk,
  input  wire logic       convStart,
  input  wire logic [2:0] convChan,
  output tma_conv_s       conv
);
  logic signed [11:0] temps  [7];
  logic               faults [7];
  // ==========
  // random wait; data churns outside the done pulse
  initial begin
    conv = '0;
    forever begin
      @(posedge clk);
      if (convStart) begin
        repeat ($urandom_range(1, 6)) @(posedge clk);
        #1 conv = '{1'b1, faults[convChan], temps[convChan]};
        @(posedge clk) #1 conv = '{1'b0, 1'b0, ~conv.temp};
      end
    end
  end
endmodule // tma_conv_model

//--- sim/tma_alarm_core_checker.sv
// port assertions for the temperature alarm core
`timescale 1ns/1ps
module tma_alarm_core_checker import tma_pkg::*; (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire tma_conv_s  conv,
  input wire logic       convStart,
  input wire logic [2:0] convChan,
  input wire logic       convFastCh1,
  input wire logic       alertOut_n,
  input wire logic       overtemp_out_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========
  // alarms assert only at a clean conversion end
  chk_fault_quiet: assert property (conv.done && conv.fault
    |=> !$fell(alertOut_n) && !$fell(overtemp_out_n)) else $error("fault");
  chk_alert_cause: assert property ($fell(alertOut_n)
    |-> $past(conv.done) && !$past(conv.fault)) else $error("alert");
  chk_overtemp_out_n_cause: assert property ($fell(overtemp_out_n)
    |-> $past(conv.done) && !$past(conv.fault)
    && $past(convChan) inside {3'h1, 3'h4, 3'h5, 3'h6}) else $error("ot");
  chk_overtemp_out_n_hold: assert property (!overtemp_out_n && !conv.done
    |=> !overtemp_out_n) else $error("overtemp dropped");
  // ==========
  // sequencer order
  chk_start_pulse: assert property (convStart |=> !convStart)
    else $error("start pulse");
  chk_next_chan: assert property (conv.done && !convFastCh1
    && convChan != 3'h6 |=> convChan == $past(convChan) + 3'h1)
    else $error("order");
  chk_fast_ch1: assert property (conv.done && convFastCh1
    && convChan != 3'h1 |=> convChan == 3'h1) else $error("fast");
  chk_reset_idle: assert property (disable iff (1'b0) !reset_n
    |=> alertOut_n && overtemp_out_n && !convStart) else $error("reset");
  cover property (conv.done && conv.fault);
  cover property ($fell(alertOut_n));
  cover property ($fell(overtemp_out_n));
endmodule // tma_alarm_core_checker
bind tma_alarm_core tma_alarm_core_checker u_chk (.clk, .reset_n, .conv,
  .convStart, .convChan, .convFastCh1, .alertOut_n, .overtemp_out_n);

//--- sim/testbench.sv
// self-checking bench for the temperature alarm core
`timescale 1ns/1ps
module testbench import tma_pkg::*;;
  logic       clk = 0, linkClk = 0, reset_n = 0, ce = 1, linkReqValid = 0;
  logic       linkReqReady, linkRspValid, convStart, convResCancel;
  logic       convFastCh1, busTimeoutEn, alertOut_n, overtemp_out_n;
  logic [2:0] convChan;
  wire  [7:0] pins = {5'h0, busTimeoutEn, convFastCh1, convResCancel};
  logic [7:0] d;
  logic [8:0] e, expQ[$];
  tma_req_s   linkReq = '0;
  tma_rsp_s   linkRsp;
  tma_conv_s  conv;
  int         fails = 0, samples_checked = 0, n;
  localparam logic [7:0] RA [6] = '{TMA_A_CFG1, TMA_A_CFG2, TMA_A_CFG3,
    8'h17, 8'h21, TMA_A_MFR};
  localparam logic [7:0] RV [6] = '{0, 0, 0, 8'h5A, 8'h6E, 8'h3C};
  // ==========
  // clocks, design and converter; the id value is arbitrary
  always #20 clk = ~clk;
  initial #1.7 forever #3 linkClk = ~linkClk;
  tma_alarm_core #(.MFR_ID(8'h3C), .FRZ_TIMEOUT(50)) dut (.*);
  tma_conv_model cm (.clk, .convStart, .convChan, .conv);
  // ==========
  // tasks
  task automatic cmp(string s, logic [7:0] x, logic [7:0] y);
    samples_checked++;
    if (y !== x) begin
      fails++;
      $display("FAIL %s exp %h got %h", s, x, y);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d mismatched %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // holds the request until ready is seen at a taking edge
  task automatic xfer(tma_kind_e k, logic [7:0] v, logic [8:0] x = 0);
    int t = 0;
    @(posedge linkClk) #1;
    linkReq = '{k, v};
    linkReqValid = 1;
    while (linkReqReady !== 1'b1) begin
      if (++t > 900) begin fails++; complete_run; end
      @(posedge linkClk) #1;
    end
    expQ.push_back(x);
    @(posedge linkClk) #1;
    linkReqValid = 0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] x);
    xfer(TMA_K_PTR, a);
    xfer(TMA_K_RD, 0, {1'b1, x});
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    xfer(TMA_K_PTR, a);
    xfer(TMA_K_WR, v);
  endtask
  task automatic wlev(bit ot, logic v, int lim = 900);
    int t = 0;
    while ((ot ? overtemp_out_n : alertOut_n) !== v && t < lim) begin
      @(posedge clk) #1;
      t++;
    end
    cmp(ot ? "overtemp" : "alert", v, ot ? overtemp_out_n : alertOut_n);
    if ((ot ? overtemp_out_n : alertOut_n) !== v) complete_run;
  endtask
  // ==========
  // answer watcher: oldest note against each answer
  always @(posedge linkClk) if (linkRspValid === 1'b1) begin
    if (expQ.size() == 0) cmp("answer", 0, 8'hFF);
    else begin
      e = expQ.pop_front();
      if (e[8]) cmp("read", e[7:0], linkRsp.data);
    end
  end
  // ==========
  // main sequence
  initial begin
    void'($urandom(32230));
    for (int i = 0; i < 7; i++) begin
      cm.temps[i] = 12'sd320;
      cm.faults[i] = 0;
    end
    repeat (3) @(posedge clk) #1;
    reset_n = 1;
    // link side lifts its reset copy late; a request before it is lost
    repeat (2) @(posedge clk) #1;
    cmp("pins", 8'h04, pins);
    foreach (RA[i]) rd(RA[i], RV[i]);
    d = $urandom;
    wr(TMA_A_CFG3, d);
    rd(TMA_A_CFG3, d & TMA_C3_WMASK);
    wr(TMA_A_CFG3, 0);
    $display("test registers done");
    cm.temps[2] = 12'sd960;
    wlev(0, 0);
    wr(TMA_A_CFG1, 8'h80);
    repeat (10) @(posedge clk);
    xfer(TMA_K_ARA, 0, {1'b1, 7'h18, 1'b0});
    cmp("alert", 0, alertOut_n);
    xfer(TMA_K_ARA_WON, 0);
    wlev(0, 1, 60);
    rd(TMA_A_STAT1, 8'h02);
    n = 0;
    repeat (100) @(posedge clk) n += convStart;
    cmp("starts", 0, 8'(n));
    wr(TMA_A_CFG1, 0);
    wlev(0, 0);
    wr(TMA_A_CFG2, 8'h02);
    wlev(0, 1);
    cm.temps[2] = 12'sd320;
    repeat (200) @(posedge clk);
    wr(TMA_A_CFG2, 0);
    $display("test alert done");
    cm.faults[3] = 1;
    cm.temps[1] = 12'sd923;
    wlev(1, 0);
    rd(TMA_A_EXT1, 8'h60);
    rd(8'h01, 8'h73);
    rd(TMA_A_STAT3, 8'h04);
    rd(TMA_A_STAT2, 8'h01);
    rd(8'h03, 8'hFF);
    cmp("alert", 1, alertOut_n);
    cm.temps[1] = 12'sd864;
    repeat (300) @(posedge clk);
    cmp("overtemp", 0, overtemp_out_n);
    cm.temps[1] = 12'sd800;
    wlev(1, 1);
    $display("test fault and overtemp done");
    wr(TMA_A_CFG1, 8'h38);
    rd(TMA_A_CFG1, 8'h38);
    cmp("pins", 8'h03, pins);
    repeat (200) @(posedge clk);
    wr(TMA_A_CFG2, $urandom);
    wr(TMA_A_CFG1, 8'h80);
    repeat (10) @(posedge clk);
    wr(TMA_A_CFG1, 8'h40);
    rd(TMA_A_CFG1, 0);
    rd(TMA_A_CFG2, 0);
    repeat (50) @(posedge clk);
    cmp("left", 0, 8'(expQ.size()));
    $display("test soft reset done");
    complete_run;
  end
endmodule // testbench
